// ### hw/framer_pkg.sv
package framer_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing: the link moves one byte per byte time; spacing rounds up to cycles
   localparam int CLK_PERIOD_NS   = 20;
   localparam int LINK_RATE_MBPS  = 100;
   localparam int BITS_PER_BYTE   = 8;
   localparam int BYTE_TIME_NS    = BITS_PER_BYTE * 1000 / LINK_RATE_MBPS;
   localparam int BYTE_CYC_RAW    = (BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BYTE_CYCLES     = (BYTE_CYC_RAW < 1) ? 1 : BYTE_CYC_RAW;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame geometry
   localparam int IDX_W           = 11;
   typedef logic [IDX_W-1:0] idx_t;
   localparam int ENCAP_LEN       = 42;
   localparam int APP_HDR_LEN     = 8;
   localparam int HDR_LEN         = ENCAP_LEN + APP_HDR_LEN;
   localparam int IP_HDR_LEN      = 20;
   localparam int UDP_HDR_LEN     = 8;
   localparam int NUM_BLOCKS      = 6;
   localparam int NUM_CHANNELS    = 64;
   localparam int AZ_BYTES        = 2;
   localparam int CH_BYTES        = 3;
   localparam int BLOCK_LEN       = AZ_BYTES + CH_BYTES * NUM_CHANNELS;
   localparam int BODY_LEN        = NUM_BLOCKS * BLOCK_LEN;
   localparam int TAIL_LEN_OFF    = 22;
   localparam int TAIL_LEN_ON     = 26;
   localparam logic [15:0] UDP_LEN_OFF =
      16'(UDP_HDR_LEN + APP_HDR_LEN + BODY_LEN + TAIL_LEN_OFF);
   localparam logic [15:0] UDP_LEN_ON  =
      16'(UDP_HDR_LEN + APP_HDR_LEN + BODY_LEN + TAIL_LEN_ON);
   localparam logic [15:0] IP_HDR_LEN16 = 16'(IP_HDR_LEN);
   localparam idx_t HDR_LAST      = idx_t'(HDR_LEN - 1);
   localparam idx_t LAST_OFF      = idx_t'(HDR_LEN + BODY_LEN + TAIL_LEN_OFF - 1);
   localparam idx_t LAST_ON       = idx_t'(HDR_LEN + BODY_LEN + TAIL_LEN_ON - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Byte offsets inside the generated header
   localparam idx_t OFS_SRC_MAC   = 11'h006;
   localparam idx_t OFS_ETYPE     = 11'h00c;
   localparam idx_t OFS_IP        = 11'h00e;
   localparam idx_t OFS_IP_TOTLEN = 11'h010;
   localparam idx_t OFS_IP_FLAGS  = 11'h014;
   localparam idx_t OFS_IP_TTL    = 11'h016;
   localparam idx_t OFS_IP_PROTO  = 11'h017;
   localparam idx_t OFS_IP_DST    = 11'h01e;
   localparam idx_t OFS_UDP       = 11'h022;
   localparam idx_t OFS_UDP_LEN   = 11'h026;
   localparam idx_t OFS_APP       = 11'h02a;

   ////////////////////////////////////////////////////////////////////////////////
   // Field values
   localparam logic [47:0] MAC_BCAST      = 48'hffff_ffff_ffff;
   localparam logic [15:0] ETHERTYPE_IPV4 = 16'h0800;
   localparam logic [7:0]  IP_VER_IHL     = 8'h45;
   localparam logic [7:0]  IP_TOS         = 8'h00;
   localparam logic [15:0] IP_FLAGS_FRAG  = 16'h4000;
   localparam logic [7:0]  IP_TTL         = 8'h40;
   localparam logic [7:0]  IP_PROTO_UDP   = 8'h11;
   localparam logic [31:0] IP_BCAST       = 32'hffff_ffff;
   localparam logic [31:0] IP_SRC_DEFAULT = 32'hc0a8_01c9;
   localparam logic [15:0] UDP_SRC_PORT   = 16'h2710;
   localparam logic [15:0] UDP_DST_PORT   = 16'h0940;
   localparam logic [15:0] UDP_CSUM_NONE  = 16'h0000;
   localparam logic [15:0] START_MARKER   = 16'heeff;
   localparam logic [7:0]  CHAN_COUNT     = 8'h40;
   localparam logic [7:0]  BLOCK_COUNT    = 8'h06;
   localparam logic [7:0]  DIST_UNIT_MM   = 8'h04;
   localparam logic [7:0]  RSVD_BYTE      = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HDR  = 2'b01,
      ST_PAY  = 2'b10
   } state_e;

endpackage : framer_pkg

// ### hw/byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 9);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// ### hw/ip_hdr_checksum.sv
`timescale 1ns/1ps
module ip_hdr_checksum (
   input  wire logic        mclk,     // System clock
   input  wire logic        srst,     // Synchronous reset
   input  wire logic [15:0] tot_len,  // IP total length
   input  wire logic [15:0] ident,    // IP identification
   input  wire logic [31:0] src_ip,   // IP source address
   output logic      [15:0] csum      // Header checksum, registered
);

   logic [15:0] csum_nxt;

   // Ones-complement fold of a wide sum back to 16 bits
   function automatic logic [15:0] fold(input logic [19:0] s);
      logic [19:0] t;
      t = {4'h0, s[15:0]} + {16'h0, s[19:16]};
      t = {4'h0, t[15:0]} + {16'h0, t[19:16]};
      return t[15:0];
   endfunction : fold

   // Sum of all header words with the checksum field taken as zero
   always_comb begin
      logic [19:0] sum;
      sum = 20'h0;
      sum = sum + {4'h0, framer_pkg::IP_VER_IHL, framer_pkg::IP_TOS};
      sum = sum + {4'h0, tot_len} + {4'h0, ident};
      sum = sum + {4'h0, framer_pkg::IP_FLAGS_FRAG};
      sum = sum + {4'h0, framer_pkg::IP_TTL, framer_pkg::IP_PROTO_UDP};
      sum = sum + {4'h0, src_ip[31:16]} + {4'h0, src_ip[15:0]};
      sum = sum + {4'h0, framer_pkg::IP_BCAST[31:16]} + {4'h0, framer_pkg::IP_BCAST[15:0]};
      csum_nxt = ~fold(sum);
   end

   // Registered so the long adder chain never sits on the byte path
   always_ff @(posedge mclk) begin
      if (srst) begin
         csum <= 16'h0000;
      end else begin
         csum <= csum_nxt;
      end
   end

endmodule : ip_hdr_checksum

// ### hw/pair_buffer.sv
`timescale 1ns/1ps
module pair_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input  wire logic   mclk,  // System clock
   input  wire logic   srst,  // Synchronous reset
   byte_stream_if.snk  wr,    // Filling side
   byte_stream_if.src  rd     // Draining side
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("pair_buffer needs a power-of-two depth of at least two");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   // Honest full and empty straight from the fill count
   assign wr.ready = (cnt_r != (PW+1)'(DEPTH));
   assign rd.valid = (cnt_r != '0);
   assign rd.data  = mem_r[rp_r];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   // Pointer and storage update
   always_comb begin
      mem_nxt = mem_r;
      if (push) begin
         mem_nxt[wp_r] = wr.data;
      end
      wp_nxt  = wp_r + PW'(push);
      rp_nxt  = rp_r + PW'(pop);
      cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      mem_r <= mem_nxt;
   end

endmodule : pair_buffer

// ### hw/point_cloud_udp_framer.sv
`timescale 1ns/1ps
// How it works
// - Bytes leave no faster than one per 100 Mbps byte time, as UDP over IPv4; after a tx_ready stall, queued bytes can leave on consecutive cycles.
// - Frame opens with 42 encapsulation bytes: MACs, type, IP header, UDP fields.
// - Destination MAC is all ones, then this unit's own source MAC.
// - Frame type bytes are 0x08 then 0x00, marking IPv4.
// - IP header says version 4, 20-byte header, no options.
// - Don't-fragment flag, offset zero, time-to-live 64, protocol 17.
// - Source IP defaults to 192.168.1.201, destination is all-ones broadcast.
// - UDP ports are 0x2710 source and 0x0940 destination.
// - UDP length is 0x04B2 with sequence off, 0x04B6 with it on.
// - Sequence off after reset; on, the tail grows from 22 to 26 bytes.
// - Payload values go least significant byte first, unsigned.
// - Payload starts with marker 0xEEFF, the 0xEE byte first.
// - Header holds 64 channels, 6 blocks, 4 mm unit; bytes 4,6,7 reserved.
// - Six 194-byte blocks follow the header: azimuth then 64 channel entries.
module point_cloud_udp_framer #(
   parameter logic [31:0] SRC_IP     = framer_pkg::IP_SRC_DEFAULT,
   parameter logic [15:0] IDENT_INIT = 16'h0001  // Arbitrary start of the ID count
) (
   input  wire logic        mclk,         // System clock, 50 MHz
   input  wire logic        srst,         // Synchronous reset, active high
   input  wire logic        frame_start,  // Pulse: begin one frame
   input  wire logic        seq_enable,   // Level: sequence option, taken at start
   input  wire logic [47:0] src_mac,      // This unit's MAC address
   input  wire logic [7:0]  pay_data,     // Body and tail byte
   input  wire logic        pay_valid,    // Body and tail byte present
   output logic             pay_ready,    // Body and tail byte taken
   output logic      [7:0]  tx_data,      // Frame byte toward the MAC
   output logic             tx_valid,     // Frame byte present
   input  wire logic        tx_ready,     // MAC takes the byte
   output logic             tx_last,      // Last byte of the frame
   output logic             frame_busy,   // A frame is being built
   output logic             frame_done    // Pulse: last byte queued
);

   localparam int HDR_BITS = framer_pkg::HDR_LEN * 8;
   localparam int PACE_W   = $clog2(framer_pkg::BYTE_CYCLES + 1);
   localparam logic [PACE_W-1:0] PACE_TOP = PACE_W'(framer_pkg::BYTE_CYCLES - 1);

   if (framer_pkg::BYTE_CYCLES < 1 || framer_pkg::HDR_LEN != 50) begin : g_chk
      $error("framer constants do not fit the byte path");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State

   framer_pkg::state_e  st_r, st_nxt;
   framer_pkg::idx_t    idx_r, idx_nxt;
   logic                seq_r, seq_nxt;
   logic [15:0]         ident_r, ident_nxt;
   logic [PACE_W-1:0]   pace_r, pace_nxt;
   logic                done_r, done_nxt;

   logic                pace_ok;
   logic                wr_fire;
   logic                wr_last;
   logic [7:0]          wr_data;
   logic [7:0]          hdr_byte;
   logic [15:0]         udp_len;
   logic [15:0]         tot_len;
   logic [15:0]         ip_csum;
   framer_pkg::idx_t    frame_last;
   logic [HDR_BITS-1:0] hdr_flat;

   byte_stream_if #(.W(9)) buf_in ();
   byte_stream_if #(.W(9)) buf_out ();

   // Picks header byte idx, byte 0 being the leftmost of the flat vector
   function automatic logic [7:0] pick_byte(input logic [HDR_BITS-1:0] flat,
                                            input framer_pkg::idx_t    idx);
      int pos;
      pos = framer_pkg::HDR_LEN - 1 - int'(idx);
      if (pos < 0) begin
         return 8'h00;
      end
      return flat[pos*8 +: 8];
   endfunction : pick_byte

   ////////////////////////////////////////////////////////////////////////////////
   // Lengths follow the sequence option latched at frame start

   assign udp_len    = seq_r ? framer_pkg::UDP_LEN_ON : framer_pkg::UDP_LEN_OFF;
   assign frame_last = seq_r ? framer_pkg::LAST_ON : framer_pkg::LAST_OFF;
   assign tot_len    = udp_len + framer_pkg::IP_HDR_LEN16;

   // Checksum is recomputed every cycle but only read well after start
   ip_hdr_checksum u_csum (
      .mclk    (mclk),
      .srst    (srst),
      .tot_len (tot_len),
      .ident   (ident_r),
      .src_ip  (SRC_IP),
      .csum    (ip_csum)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Header image: network order up to the UDP checksum, then payload header

   // Encapsulation fields in their documented order
   assign hdr_flat = {
      framer_pkg::MAC_BCAST, src_mac,
      framer_pkg::ETHERTYPE_IPV4,
      framer_pkg::IP_VER_IHL, framer_pkg::IP_TOS,
      tot_len, ident_r,
      framer_pkg::IP_FLAGS_FRAG,
      framer_pkg::IP_TTL, framer_pkg::IP_PROTO_UDP,
      ip_csum,
      SRC_IP, framer_pkg::IP_BCAST,
      framer_pkg::UDP_SRC_PORT, framer_pkg::UDP_DST_PORT,
      udp_len, framer_pkg::UDP_CSUM_NONE,
      framer_pkg::START_MARKER,
      framer_pkg::CHAN_COUNT, framer_pkg::BLOCK_COUNT,
      framer_pkg::RSVD_BYTE, framer_pkg::DIST_UNIT_MM,
      framer_pkg::RSVD_BYTE, framer_pkg::RSVD_BYTE
   };

   assign hdr_byte = pick_byte(hdr_flat, idx_r);

   ////////////////////////////////////////////////////////////////////////////////
   // Byte path into the buffer

   // A byte may go only once the byte time since the last one has passed
   assign pace_ok   = (pace_r == PACE_TOP);
   assign pay_ready = (st_r == framer_pkg::ST_PAY) && pace_ok && buf_in.ready;
   assign wr_fire   = pace_ok && buf_in.ready &&
                      ((st_r == framer_pkg::ST_HDR) ||
                       ((st_r == framer_pkg::ST_PAY) && pay_valid));
   // Body and tail pass untouched, so their byte order is the producer's
   assign wr_data   = (st_r == framer_pkg::ST_HDR) ? hdr_byte : pay_data;
   assign wr_last   = (st_r == framer_pkg::ST_PAY) && (idx_r == frame_last);

   assign buf_in.valid = wr_fire;
   assign buf_in.data  = {wr_last, wr_data};

   // Two entries ride out a one-byte stall of the MAC without a bubble
   pair_buffer #(.WIDTH(9), .DEPTH(2)) u_buf (
      .mclk (mclk),
      .srst (srst),
      .wr   (buf_in),
      .rd   (buf_out)
   );

   assign tx_valid      = buf_out.valid;
   assign tx_data       = buf_out.data[7:0];
   assign tx_last       = buf_out.data[8];
   assign buf_out.ready = tx_ready;
   assign frame_busy    = (st_r != framer_pkg::ST_IDLE);
   assign frame_done    = done_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: idle, header bytes, then counted payload bytes

   always_comb begin
      st_nxt    = st_r;
      idx_nxt   = idx_r;
      seq_nxt   = seq_r;
      ident_nxt = ident_r;
      done_nxt  = 1'b0;
      // Saturating divider restarts on each byte so spacing never shrinks
      if (wr_fire) begin
         pace_nxt = '0;
      end else if (!pace_ok) begin
         pace_nxt = pace_r + PACE_W'(1);
      end else begin
         pace_nxt = pace_r;
      end
      case (st_r)
         framer_pkg::ST_IDLE: begin
            // Option is frozen for the frame so lengths stay consistent
            if (frame_start) begin
               seq_nxt = seq_enable;
               idx_nxt = '0;
               st_nxt  = framer_pkg::ST_HDR;
            end
         end
         framer_pkg::ST_HDR: begin
            if (wr_fire) begin
               idx_nxt = idx_r + framer_pkg::idx_t'(1);
               if (idx_r == framer_pkg::HDR_LAST) begin
                  st_nxt = framer_pkg::ST_PAY;
               end
            end
         end
         framer_pkg::ST_PAY: begin
            if (wr_fire) begin
               idx_nxt = idx_r + framer_pkg::idx_t'(1);
               if (wr_last) begin
                  st_nxt    = framer_pkg::ST_IDLE;
                  ident_nxt = ident_r + 16'h0001;
                  done_nxt  = 1'b1;
               end
            end
         end
         default: begin
            st_nxt = framer_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r    <= framer_pkg::ST_IDLE;
         idx_r   <= '0;
         seq_r   <= 1'b0;
         ident_r <= IDENT_INIT;
         pace_r  <= '0;
         done_r  <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         idx_r   <= idx_nxt;
         seq_r   <= seq_nxt;
         ident_r <= ident_nxt;
         pace_r  <= pace_nxt;
         done_r  <= done_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the bytes handed to the buffer

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   logic hdr_wr;
   assign hdr_wr = wr_fire && (st_r == framer_pkg::ST_HDR);

   sequence s_marker_hi;
      hdr_wr && (idx_r == framer_pkg::OFS_APP);
   endsequence

   sequence s_marker_lo;
      hdr_wr && (idx_r == framer_pkg::OFS_APP + 11'h001);
   endsequence

   AST_PACE_SPACING: assert property (wr_fire |=> !wr_fire [*3])
      else $error("bytes closer than one byte time");

   AST_HDR_TO_PAY: assert property (
      (hdr_wr && idx_r == framer_pkg::HDR_LAST) |=> (st_r == framer_pkg::ST_PAY))
      else $error("payload did not follow header");

   AST_MAC_BCAST: assert property (
      (hdr_wr && idx_r < framer_pkg::OFS_SRC_MAC) |-> (wr_data == 8'hff))
      else $error("destination MAC not broadcast");

   AST_ETYPE: assert property (
      hdr_wr && (idx_r == framer_pkg::OFS_ETYPE || idx_r == framer_pkg::OFS_ETYPE + 11'h001)
      |-> (wr_data == ((idx_r == framer_pkg::OFS_ETYPE) ? 8'h08 : 8'h00)))
      else $error("frame type wrong");

   AST_IP_VER: assert property (
      (hdr_wr && idx_r == framer_pkg::OFS_IP) |-> (wr_data == 8'h45))
      else $error("IP version or header length wrong");

   AST_IP_FLAGS: assert property (
      (hdr_wr && idx_r == framer_pkg::OFS_IP_FLAGS) |-> (wr_data == 8'h40))
      else $error("IP flags wrong");

   AST_IP_TTL_PROTO: assert property (
      (hdr_wr && idx_r == framer_pkg::OFS_IP_TTL) |-> (wr_data == 8'h40) ##4
      (!hdr_wr || idx_r != framer_pkg::OFS_IP_PROTO || wr_data == 8'h11))
      else $error("TTL or protocol wrong");

   AST_IP_DST: assert property (
      (hdr_wr && idx_r >= framer_pkg::OFS_IP_DST && idx_r < framer_pkg::OFS_UDP)
      |-> (wr_data == 8'hff))
      else $error("IP destination not broadcast");

   AST_UDP_PORTS: assert property (
      (hdr_wr && idx_r == framer_pkg::OFS_UDP + 11'h002) |-> (wr_data == 8'h09))
      else $error("UDP destination port wrong");

   AST_UDP_LEN: assert property (
      (hdr_wr && idx_r == framer_pkg::OFS_UDP_LEN + 11'h001)
      |-> (wr_data == (seq_r ? 8'hb6 : 8'hb2)))
      else $error("UDP length wrong");

   AST_FRAME_LEN: assert property (
      (wr_fire && wr_last) |-> (idx_r == (seq_r ? 11'h4d7 : 11'h4d3)))
      else $error("frame length wrong");

   AST_MARKER: assert property (s_marker_hi |-> (wr_data == 8'hee))
      else $error("start marker high byte wrong");

   AST_MARKER_LO: assert property (s_marker_lo |-> (wr_data == 8'hff))
      else $error("start marker low byte wrong");

   AST_APP_COUNTS: assert property (
      (hdr_wr && idx_r == framer_pkg::OFS_APP + 11'h002) |-> (wr_data == 8'h40))
      else $error("channel count wrong");

   AST_TOTLEN: assert property (
      (hdr_wr && idx_r == framer_pkg::OFS_IP_TOTLEN + 11'h001)
      |-> (wr_data == (seq_r ? 8'hca : 8'hc6)))
      else $error("IP total length wrong");

endmodule : point_cloud_udp_framer

// ### test/mac_sink.sv
`timescale 1ns/1ps
// Host-side receiver: swallows every byte the framer offers and keeps it for inspection
module mac_sink (
   input  wire logic       mclk,      // System clock
   input  wire logic       srst,      // Synchronous reset
   input  wire logic       clear,     // Forget the captured frame
   input  wire logic       slow,      // Accept one byte in eight cycles
   input  wire logic [7:0] tx_data,   // Frame byte
   input  wire logic       tx_valid,  // Frame byte present
   input  wire logic       tx_last,   // Last byte marker
   output logic            tx_ready   // Byte accepted
);
   logic [7:0] rx [0:1299];
   int         n_rx;
   int         last_idx;
   int         last_cnt;
   logic [2:0] slot_r;

   ////////////////////////////////////////////////////////////////////////////
   // Capture; slow mode stalls long enough to fill the two-entry buffer
   always_ff @(posedge mclk) begin
      slot_r <= slot_r + 3'h1;
      tx_ready <= srst ? 1'b0 : (slow ? (slot_r == 3'h0) : 1'b1);
      if (srst || clear) begin
         n_rx     <= 0;
         last_cnt <= 0;
         slot_r   <= 3'h0;
      end else if (tx_valid && tx_ready) begin
         rx[n_rx] <= tx_data;
         n_rx     <= n_rx + 1;
         if (tx_last) begin
            last_idx <= n_rx;
            last_cnt <= last_cnt + 1;
         end
      end
   end
endmodule : mac_sink

// ### test/point_cloud_udp_framer_tb.sv
`timescale 1ns/1ps
module point_cloud_udp_framer_tb;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        frame_start = 1'b0;
   logic        seq_enable = 1'b0;
   logic [47:0] src_mac = 48'h02_11_22_33_44_55;
   logic [7:0]  pay_data = 8'h00;
   logic        pay_valid = 1'b0;
   logic        pay_ready, tx_valid, tx_ready, tx_last, frame_busy, frame_done;
   logic [7:0]  tx_data;
   logic        clear = 1'b0;
   logic        slow = 1'b0;
   int          fails = 0;
   int          n_tests = 0;
   int          cyc = 0;

   always #10 mclk = ~mclk;

   point_cloud_udp_framer dut (.mclk(mclk), .srst(srst), .frame_start(frame_start),
      .seq_enable(seq_enable), .src_mac(src_mac), .pay_data(pay_data),
      .pay_valid(pay_valid), .pay_ready(pay_ready), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last),
      .frame_busy(frame_busy), .frame_done(frame_done));

   mac_sink sink (.mclk(mclk), .srst(srst), .clear(clear), .slow(slow), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and hang guard
   task automatic final_report();
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   ////////////////////////////////////////////////////////////////////////////
   // Expected frame byte: network fields big-endian, payload steps by 7 from 3
   function automatic logic [7:0] exp_byte(int k, bit seq, logic [15:0] id);
      logic [15:0]  ul, tl, cs;
      logic [31:0]  s;
      logic [399:0] hv;
      ul = seq ? 16'h04b6 : 16'h04b2;
      tl = ul + 16'h0014;
      s = 32'h4500 + tl + id + 32'h4000 + 32'h4011 + 32'hc0a8 + 32'h01c9 + 32'h1fffe;
      s = s[15:0] + s[31:16];
      s = s[15:0] + s[31:16];
      cs = ~s[15:0];
      hv = {48'hffff_ffff_ffff, src_mac, 16'h0800, 16'h4500, tl, id, 16'h4000, 16'h4011,
            cs, 32'hc0a8_01c9, 32'hffff_ffff, 16'h2710, 16'h0940, ul, 16'h0000,
            64'heeff_4006_0004_0000};
      return (k < 50) ? hv[399-8*k -: 8] : 8'((k - 50) * 7 + 3);
   endfunction : exp_byte

   // One frame: start, feed body and tail, then compare everything the host saw
   task automatic run_frame(input bit seq, input bit slow_rx, input logic [15:0] id,
                            input bit poke);
      int len;
      int w;
      logic [7:0] rx_b;
      logic [7:0] ex_b;
      len = seq ? 1240 : 1236;
      clear <= 1'b1;
      slow <= slow_rx;
      seq_enable <= seq;
      frame_start <= 1'b1;
      @(posedge mclk);
      clear <= 1'b0;
      frame_start <= 1'b0;
      seq_enable <= ~seq;  // Option must be latched at start only
      for (int i = 0; i < len - 50; i++) begin
         pay_data <= 8'(i * 7 + 3);
         pay_valid <= 1'b1;
         do @(negedge mclk); while (pay_ready !== 1'b1);
         if (i == 0) chk({15'h0, frame_busy}, 16'h0001);
         @(posedge mclk);
         frame_start <= poke && (i == 100);  // Start while busy must be ignored
      end
      pay_valid <= 1'b0;
      frame_start <= 1'b0;
      // Done pulse stands for the one cycle after the last byte is queued
      @(negedge mclk);
      chk({15'h0, frame_done}, 16'h0001);
      chk({15'h0, frame_busy}, 16'h0000);
      w = 0;
      while (sink.n_rx < len && w < 400) begin
         @(negedge mclk);
         w++;
      end
      repeat (3) @(negedge mclk);
      chk(16'(sink.n_rx), 16'(len));
      chk(16'(sink.last_idx), 16'(len - 1));
      chk(16'(sink.last_cnt), 16'h0001);
      chk({15'h0, frame_busy}, 16'h0000);
      // Every byte the host saw, grouped by the fields it belongs to
      for (int k = 0; k < len; k++) begin
         rx_b = sink.rx[k];
         ex_b = exp_byte(k, seq, id);
         if (k < 14) chk({8'h0, rx_b}, {8'h0, ex_b});
         else if (k < 34) chk({8'h0, rx_b}, {8'h0, ex_b});
         else if (k < 42) chk({8'h0, rx_b}, {8'h0, ex_b});
         else if (k < 50) chk({8'h0, rx_b}, {8'h0, ex_b});
         else chk({8'h0, rx_b}, {8'h0, ex_b});
      end
   endtask : run_frame

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_seq_off_prompt();
      run_frame(1'b0, 1'b0, 16'h0001, 1'b0);
   endtask : t_seq_off_prompt

   task automatic t_seq_on_stalled_refused_start();
      run_frame(1'b1, 1'b1, 16'h0002, 1'b1);
   endtask : t_seq_on_stalled_refused_start

   task automatic t_seq_off_after_on();
      run_frame(1'b0, 1'b1, 16'h0003, 1'b0);
   endtask : t_seq_off_after_on

   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_seq_off_prompt();
      t_seq_on_stalled_refused_start();
      t_seq_off_after_on();
      final_report();
   end
endmodule : point_cloud_udp_framer_tb
